// *** irc_pkg.sv ***
`default_nettype none
package irc_pkg;

   // clock rate and position widths
   localparam int CLK_MHZ = 20;
   localparam int POS_BITS = 18;
   localparam int ANG_BITS = 12;

   // register offsets
   localparam logic [6:0] ADDR_RATE_EN = 7'h15;
   localparam logic [6:0] ADDR_HYS_PH = 7'h16;
   localparam logic [6:0] ADDR_POLES = 7'h17;
   localparam logic [6:0] ADDR_EFF_LO = 7'h23;
   localparam logic [6:0] ADDR_EFF_HI = 7'h24;
   localparam logic [6:0] ADDR_START_LO = 7'h28;
   localparam logic [6:0] ADDR_START_HI = 7'h29;
   localparam logic [6:0] ADDR_START_LO_SER = 7'h4b;
   localparam logic [6:0] ADDR_START_HI_SER = 7'h4c;

   // field positions
   localparam int RATE_LSB = 0;
   localparam int HIDE_BIT = 4;
   localparam int STEP_LSB = 5;
   localparam int INV_BIT = 7;
   localparam int PHASE_BIT = 3;
   localparam int HYS_LSB = 4;
   localparam int POLE_BITS = 6;
   localparam int LOW_NIB_LSB = 4;

   // reset values
   localparam logic [7:0] RATE_EN_RST = 8'h00;
   localparam logic [7:0] HYS_PH_RST = 8'h00;
   localparam logic [5:0] POLES_RST = 6'h02;
   localparam logic [11:0] START_RST = 12'h000;

   // minimum edge spacing per rate code, ns
   localparam int T_MTD_NS [8] = '{40, 80, 160, 320, 640, 1280, 5120, 20480};
   localparam int CNT_BITS = 16;

   // reversal hysteresis, 1e-4 degree; 0..3 by step size, 4..6 by code 1..3
   localparam int HYS_E4DEG [7] = '{14, 41, 96, 210, 1750, 3500, 7000};
   localparam longint E4DEG_PER_TURN = 3600000;

   // commutation: fixed 0.0879 deg is one 12-bit angle step
   localparam logic [11:0] COMM_HYS = 12'h001;
   localparam logic [11:0] PH120_V = 12'h555;
   localparam logic [11:0] PH120_W = 12'haab;
   localparam logic [11:0] PH60_V = 12'h2ab;
   localparam logic [11:0] PH60_W = 12'h555;
   localparam logic [2:0] PORTB_COMM = 3'h1;

   // overspeed when output lags by more than this many steps
   localparam int OVS_LAG_STEPS = 64;

   typedef struct packed {
      logic [6:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } irc_reg_req_s;

   typedef struct packed {
      logic a;
      logic b;
      logic step;
      logic dir;
      logic up;
      logic down;
   } irc_quad_s;

   typedef struct packed {
      logic u;
      logic v;
      logic w;
   } irc_comm_s;

   function automatic logic [CNT_BITS-1:0] mtd_cycles(input logic [2:0] code);
      int c;
      c = (T_MTD_NS[code] * CLK_MHZ + 999) / 1000;
      if (c < 1) begin
         c = 1;
      end
      return CNT_BITS'(c);
   endfunction

   function automatic logic [POS_BITS-1:0] hys_lsb(input logic [1:0] sel,
                                                   input logic [1:0] ss);
      int idx;
      longint v;
      idx = (sel == 2'h0) ? int'(ss) : int'(sel) + 3;
      v = (longint'(HYS_E4DEG[idx]) * (longint'(1) << POS_BITS)) / E4DEG_PER_TURN;
      return POS_BITS'(v);
   endfunction

   function automatic logic [4:0] pole_count(input logic [5:0] code);
      logic [6:0] n;
      n = 7'((7'(code) + 7'h01) / 7'h03);
      if (n < 7'h01) begin
         n = 7'h01;
      end else if (n > 7'h10) begin
         n = 7'h10;
      end
      return 5'(n);
   endfunction

endpackage
`default_nettype wire

// *** irc_rate_gate.sv ***
`timescale 1ns/1ps
`default_nettype none
module irc_rate_gate (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // rate selection
   input wire logic [2:0] rate_code,
   // event handshake
   input wire logic fire,
   output logic ready
);

   typedef struct packed {
      logic [irc_pkg::CNT_BITS-1:0] cnt;
   } irc_gate_st_s;

   irc_gate_st_s s_r;
   irc_gate_st_s s_nxt;

   // spacing elapsed since the last event
   assign ready = (s_r.cnt >= irc_pkg::mtd_cycles(rate_code));

   always_comb begin
      s_nxt = s_r;
      if (fire) begin
         s_nxt.cnt = {{(irc_pkg::CNT_BITS-1){1'b0}}, 1'b1};
      end else if (s_r.cnt != {irc_pkg::CNT_BITS{1'b1}}) begin
         s_nxt.cnt = s_r.cnt + {{(irc_pkg::CNT_BITS-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '{cnt: {irc_pkg::CNT_BITS{1'b1}}};
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule
`default_nettype wire

// *** irc_comm.sv ***
`timescale 1ns/1ps
`default_nettype none
module irc_comm (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // angle and setup
   input wire logic [11:0] angle,
   input wire logic [5:0] pole_code,
   input wire logic phase60,
   input wire logic enable,
   // commutation outputs
   output irc_pkg::irc_comm_s comm
);

   typedef struct packed {
      logic [11:0] filt;
      irc_pkg::irc_comm_s out;
   } irc_comm_st_s;

   irc_comm_st_s s_r;
   irc_comm_st_s s_nxt;
   logic [11:0] diff;
   logic [11:0] mag;
   logic [16:0] prod;
   logic [11:0] ph;
   logic [11:0] pv;
   logic [11:0] pw;

   assign comm = s_r.out;

   always_comb begin
      s_nxt = s_r;
      diff = angle - s_r.filt;
      mag = diff[11] ? (~diff + 12'h001) : diff;
      if (mag > irc_pkg::COMM_HYS) begin
         s_nxt.filt = angle;
      end
      prod = 17'(s_nxt.filt) * 17'(irc_pkg::pole_count(pole_code));
      ph = prod[11:0];
      pv = ph - (phase60 ? irc_pkg::PH60_V : irc_pkg::PH120_V);
      pw = ph - (phase60 ? irc_pkg::PH60_W : irc_pkg::PH120_W);
      s_nxt.out.u = enable & ~ph[11];
      s_nxt.out.v = enable & ~pv[11];
      s_nxt.out.w = enable & ~pw[11];
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule
`default_nettype wire

// *** irc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module irc_top (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // position source
   input wire logic [irc_pkg::POS_BITS-1:0] pos_abs,
   input wire logic op_point_reached,
   input wire logic [11:0] nonius_offset,
   input wire logic [11:0] mt_offset,
   input wire logic mt_configured,
   // restart commands
   input wire logic soft_reset_cmd,
   input wire logic absolute_restart_cmd,
   // port mode
   input wire logic [2:0] port_b_mode,
   // register port
   input wire irc_pkg::irc_reg_req_s reg_req,
   output logic [7:0] reg_rdata,
   // incremental outputs
   output irc_pkg::irc_quad_s quad,
   output logic if_enabled,
   output logic overspeed_flag,
   // commutation outputs
   output irc_pkg::irc_comm_s comm,
   output logic comm_active
);

   localparam int PB = irc_pkg::POS_BITS;
   localparam logic [PB-1:0] ONE = {{(PB-1){1'b0}}, 1'b1};

   typedef struct packed {
      logic [7:0] rate_en;
      logic [7:0] hys_ph;
      logic [5:0] poles;
      logic [11:0] start;
      logic [11:0] eff;
      logic [7:0] rdata;
      logic starting;
      logic [PB-1:0] filt;
      logic fdir_down;
      logic [PB-1:0] out_cnt;
      logic ovs;
      irc_pkg::irc_quad_s q;
   } irc_st_s;

   irc_st_s s_r;
   irc_st_s s_nxt;

   logic invert;
   logic hide;
   logic [1:0] step_sz;
   logic [2:0] rate_code;
   logic [1:0] hys_sel;
   logic rate_ready;
   logic fire;
   logic active;
   logic [PB-1:0] pd;
   logic [PB-1:0] diff;
   logic [PB-1:0] mag;
   logic [PB-1:0] tgt_pos;
   logic [PB-1:0] out_pos;
   logic [PB-1:0] lag;
   logic [PB-1:0] lag_mag;
   logic [11:0] pos12;
   logic [11:0] comm_angle;
   logic [7:0] rd_val;

   assign invert = s_r.rate_en[irc_pkg::INV_BIT];
   assign hide = s_r.rate_en[irc_pkg::HIDE_BIT];
   assign step_sz = s_r.rate_en[irc_pkg::STEP_LSB +: 2];
   assign rate_code = s_r.rate_en[irc_pkg::RATE_LSB +: 3];
   assign hys_sel = s_r.hys_ph[irc_pkg::HYS_LSB +: 2];

   assign quad = s_r.q;
   assign overspeed_flag = s_r.ovs;
   assign reg_rdata = s_r.rdata;
   assign active = !(s_r.starting && hide);
   assign if_enabled = active;
   assign comm_active = (port_b_mode == irc_pkg::PORTB_COMM) && !s_r.starting;

   irc_rate_gate u_gate (
      .clock(clock),
      .rst(rst),
      .rate_code(rate_code),
      .fire(fire),
      .ready(rate_ready)
   );

   // commutation angle: position, direction, effective offset
   assign pos12 = pos_abs[PB-1 -: 12];
   assign comm_angle = (invert ? (~pos12 + 12'h001) : pos12) + s_r.eff;

   irc_comm u_comm (
      .clock(clock),
      .rst(rst),
      .angle(comm_angle),
      .pole_code(s_r.poles),
      .phase60(s_r.hys_ph[irc_pkg::PHASE_BIT]),
      .enable(comm_active),
      .comm(comm)
   );

   // register read mux
   always_comb begin
      rd_val = 8'h00;
      if (reg_req.addr == irc_pkg::ADDR_RATE_EN) begin
         rd_val = s_r.rate_en;
      end else if (reg_req.addr == irc_pkg::ADDR_HYS_PH) begin
         rd_val = s_r.hys_ph;
      end else if (reg_req.addr == irc_pkg::ADDR_POLES) begin
         rd_val = {2'b00, s_r.poles};
      end else if (reg_req.addr == irc_pkg::ADDR_EFF_LO) begin
         rd_val = {s_r.eff[3:0], 4'h0};
      end else if (reg_req.addr == irc_pkg::ADDR_EFF_HI) begin
         rd_val = s_r.eff[11:4];
      end else if (reg_req.addr == irc_pkg::ADDR_START_LO ||
                   reg_req.addr == irc_pkg::ADDR_START_LO_SER) begin
         rd_val = {s_r.start[3:0], 4'h0};
      end else if (reg_req.addr == irc_pkg::ADDR_START_HI ||
                   reg_req.addr == irc_pkg::ADDR_START_HI_SER) begin
         rd_val = s_r.start[11:4];
      end
   end

   always_comb begin
      s_nxt = s_r;
      fire = 1'b0;
      s_nxt.q.step = 1'b0;
      s_nxt.q.up = 1'b0;
      s_nxt.q.down = 1'b0;

      // register writes; effective offset has no write path
      if (reg_req.wr) begin
         if (reg_req.addr == irc_pkg::ADDR_RATE_EN) begin
            s_nxt.rate_en = reg_req.wdata;
         end else if (reg_req.addr == irc_pkg::ADDR_HYS_PH) begin
            s_nxt.hys_ph = reg_req.wdata;
         end else if (reg_req.addr == irc_pkg::ADDR_POLES) begin
            s_nxt.poles = reg_req.wdata[irc_pkg::POLE_BITS-1:0];
         end else if (reg_req.addr == irc_pkg::ADDR_START_LO ||
                      reg_req.addr == irc_pkg::ADDR_START_LO_SER) begin
            s_nxt.start[3:0] = reg_req.wdata[irc_pkg::LOW_NIB_LSB +: 4];
         end else if (reg_req.addr == irc_pkg::ADDR_START_HI ||
                      reg_req.addr == irc_pkg::ADDR_START_HI_SER) begin
            s_nxt.start[11:4] = reg_req.wdata;
         end
      end
      if (reg_req.rd) begin
         s_nxt.rdata = rd_val;
      end

      // reversal hysteresis on direction-corrected position
      pd = invert ? (~pos_abs + ONE) : pos_abs;
      diff = pd - s_r.filt;
      mag = diff[PB-1] ? (~diff + ONE) : diff;
      if (diff != '0) begin
         if (diff[PB-1] == s_r.fdir_down) begin
            s_nxt.filt = pd;
         end else if (mag > irc_pkg::hys_lsb(hys_sel, step_sz)) begin
            s_nxt.filt = pd;
            s_nxt.fdir_down = diff[PB-1];
         end
      end

      // output counter walks toward the filtered position
      tgt_pos = s_r.filt & ({PB{1'b1}} << step_sz);
      out_pos = s_r.out_cnt << step_sz;
      lag = tgt_pos - out_pos;
      lag_mag = lag[PB-1] ? (~lag + ONE) : lag;
      if (active && lag != '0 && rate_ready) begin
         fire = 1'b1;
         if (lag[PB-1]) begin
            s_nxt.out_cnt = s_r.out_cnt - ONE;
            s_nxt.q.down = 1'b1;
            s_nxt.q.dir = 1'b0;
         end else begin
            s_nxt.out_cnt = s_r.out_cnt + ONE;
            s_nxt.q.up = 1'b1;
            s_nxt.q.dir = 1'b1;
         end
         s_nxt.q.step = 1'b1;
      end
      // startup completes at the operating point
      if (s_r.starting && op_point_reached) begin
         s_nxt.starting = 1'b0;
         s_nxt.eff = s_r.start + nonius_offset +
                     (mt_configured ? mt_offset : 12'h000);
         if (hide) begin
            s_nxt.out_cnt = s_r.filt >> step_sz;
            fire = 1'b0;
            s_nxt.q.step = 1'b0;
            s_nxt.q.up = 1'b0;
            s_nxt.q.down = 1'b0;
         end
      end
      if (soft_reset_cmd || absolute_restart_cmd) begin
         s_nxt.starting = 1'b1;
         s_nxt.ovs = 1'b0;
      end
      // set wins over a restart in the same cycle
      if (active && (lag_mag >> step_sz) > PB'(irc_pkg::OVS_LAG_STEPS)) begin
         s_nxt.ovs = 1'b1;
      end

      s_nxt.q.a = s_nxt.out_cnt[1];
      s_nxt.q.b = s_nxt.out_cnt[1] ^ s_nxt.out_cnt[0];
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s_r <= '{rate_en: irc_pkg::RATE_EN_RST,
                  hys_ph: irc_pkg::HYS_PH_RST,
                  poles: irc_pkg::POLES_RST,
                  start: irc_pkg::START_RST,
                  starting: 1'b1,
                  default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

endmodule
`default_nettype wire

// *** irc_far_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module irc_far_end #(
   parameter int MIN_GAP = 1
) (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // incremental input
   input wire irc_pkg::irc_quad_s quad,
   // counter state
   output logic signed [15:0] count,
   output logic too_close
);
   logic [1:0] ab_r;
   int gap;
   // decodes a/b like an external counter
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count <= '0;
         too_close <= 1'b0;
         ab_r <= 2'h0;
         gap <= MIN_GAP;
      end else begin
         ab_r <= {quad.a, quad.b};
         gap <= quad.step ? 1 : gap + 1;
         if (quad.step && gap < MIN_GAP) begin
            too_close <= 1'b1;
         end
         if ({quad.a, quad.b} != ab_r) begin
            count <= count + (({quad.a, quad.b} == {ab_r[0], ~ab_r[1]}) ? 16'sd1 : -16'sd1);
         end
      end
   end
endmodule
`default_nettype wire

// *** irc_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module irc_top_assertions (
   // clock and reset
   input wire logic clock,
   input wire logic rst,
   // watched ports
   input wire irc_pkg::irc_reg_req_s reg_req,
   input wire logic [2:0] port_b_mode,
   input wire logic soft_reset_cmd,
   input wire logic absolute_restart_cmd,
   input wire irc_pkg::irc_quad_s quad,
   input wire logic if_enabled,
   input wire logic overspeed_flag,
   input wire irc_pkg::irc_comm_s comm,
   input wire logic comm_active
);
   localparam logic [8:0] LIM [8] = '{9'h001, 9'h002, 9'h004, 9'h007,
                                       9'h00d, 9'h01a, 9'h067, 9'h19a};
   logic [2:0] rate_r;
   logic [8:0] gap_r;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   // rate shadow and cycles since last step
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rate_r <= 3'h0;
         gap_r <= 9'h1ff;
      end else begin
         if (reg_req.wr && reg_req.addr == irc_pkg::ADDR_RATE_EN) begin
            rate_r <= reg_req.wdata[2:0];
         end
         gap_r <= quad.step ? 9'h001 : ((gap_r == 9'h1ff) ? gap_r : gap_r + 9'h001);
      end
   end
   a_step_spacing: assert property (quad.step |-> gap_r >= LIM[rate_r])
      else $error("step edges too close");
   a_step_kind: assert property (quad.step |-> (quad.dir ? (quad.up && !quad.down) : (quad.down && !quad.up)))
      else $error("step without matching up or down");
   a_ab_needs_step: assert property ($changed({quad.a, quad.b}) && !$rose(if_enabled)
      |-> quad.step)
      else $error("a/b moved without step");
   a_jam_silent: assert property ($rose(if_enabled) |-> !quad.step)
      else $error("step pulse at interface enable");
   a_up_gray: assert property (quad.up |-> {quad.a, quad.b} == {$past(quad.b), !$past(quad.a)})
      else $error("up edge out of order");
   a_down_gray: assert property (quad.down |-> {quad.a, quad.b} == {!$past(quad.b), $past(quad.a)})
      else $error("down edge out of order");
   a_enable_gate: assert property (!if_enabled |=> !quad.step)
      else $error("step while disabled");
   a_mode_gate: assert property (comm_active |-> port_b_mode == irc_pkg::PORTB_COMM)
      else $error("commutation active in wrong mode");
   a_comm_quiet: assert property (!comm_active ##1 !comm_active |-> comm == 3'h0)
      else $error("commutation output while inactive");
   a_ovs_sticky: assert property (overspeed_flag && !soft_reset_cmd && !absolute_restart_cmd |=> overspeed_flag)
      else $error("overspeed flag dropped");
   c_up: cover property (quad.up);
   c_down: cover property (quad.down);
   c_comm: cover property (comm_active);
   c_ovs: cover property (overspeed_flag);
endmodule
bind irc_top irc_top_assertions i_chk (.clock(clock), .rst(rst), .reg_req(reg_req),
   .port_b_mode(port_b_mode), .soft_reset_cmd(soft_reset_cmd),
   .absolute_restart_cmd(absolute_restart_cmd), .quad(quad), .if_enabled(if_enabled),
   .overspeed_flag(overspeed_flag), .comm(comm), .comm_active(comm_active));
`default_nettype wire

// *** irc_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module irc_top_test;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic [17:0] pos = '0;
   logic op = 1'b0;
   logic [11:0] nonius = '0;
   logic [11:0] mtoff = '0;
   logic mtc = 1'b0;
   logic srst = 1'b0;
   logic arst = 1'b0;
   logic [2:0] pbm = 3'h0;
   irc_pkg::irc_reg_req_s req = '0;
   logic [7:0] rdata;
   irc_pkg::irc_quad_s quad;
   logic if_en;
   logic ovs;
   irc_pkg::irc_comm_s comm;
   logic cact;
   logic signed [15:0] count;
   logic too_close;
   int fails = 0;
   int check_count = 0;
   always #25 clock = ~clock;
   irc_top i_dut (.clock(clock), .rst(rst), .pos_abs(pos), .op_point_reached(op),
      .nonius_offset(nonius), .mt_offset(mtoff), .mt_configured(mtc),
      .soft_reset_cmd(srst), .absolute_restart_cmd(arst), .port_b_mode(pbm),
      .reg_req(req), .reg_rdata(rdata), .quad(quad), .if_enabled(if_en),
      .overspeed_flag(ovs), .comm(comm), .comm_active(cact));
   irc_far_end i_far (.clock(clock), .rst(rst), .quad(quad), .count(count),
      .too_close(too_close));
   task automatic finish_test;
      $display("checks %0d fails %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
      req <= '{a, w, !w, d};
      @(posedge clock);
      req <= '0;
      @(posedge clock);
   endtask
   task automatic rc(input logic [6:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(rdata, e);
   endtask
   task automatic cmd(input logic abs);
      if (abs) arst <= 1'b1;
      else srst <= 1'b1;
      @(posedge clock);
      arst <= 1'b0;
      srst <= 1'b0;
   endtask
   function automatic logic [2:0] uvw(input logic [17:0] p, input int n, input logic s,
                                      input logic inv);
      logic [11:0] a;
      logic [11:0] ph;
      a = (inv ? -p[17:6] : p[17:6]) + 12'h579;
      ph = 12'(a * n);
      return {ph < 12'h800, 12'(ph - (s ? 12'h2ab : 12'h555)) < 12'h800,
              12'(ph - (s ? 12'h555 : 12'haab)) < 12'h800};
   endfunction
   task automatic t_regs;
      rc(irc_pkg::ADDR_RATE_EN, 8'h00);
      rc(irc_pkg::ADDR_POLES, 8'h02);
      acc(1'b1, irc_pkg::ADDR_POLES, 8'hef);
      rc(irc_pkg::ADDR_POLES, 8'h2f);
      acc(1'b1, irc_pkg::ADDR_HYS_PH, 8'h5a);
      rc(irc_pkg::ADDR_HYS_PH, 8'h5a);
      acc(1'b1, irc_pkg::ADDR_HYS_PH, 8'h00);
      acc(1'b1, irc_pkg::ADDR_START_LO_SER, 8'hab);
      rc(irc_pkg::ADDR_START_LO, 8'ha0);
      rc(7'h7f, 8'h00);
   endtask
   task automatic t_rate;
      int lim[8] = '{1, 2, 4, 7, 13, 26, 103, 410};
      int n;
      int last;
      int gmin;
      for (int c = 0; c < 8; c++) begin
         acc(1'b1, irc_pkg::ADDR_RATE_EN, 8'(c));
         pos <= pos + 18'h8;
         n = 0;
         last = -1000;
         gmin = 1000;
         for (int t = 0; t < 8 * lim[c] + 20; t++) begin
            wt(1);
            if (quad.step === 1'b1) begin
               gmin = (t - last < gmin) ? t - last : gmin;
               last = t;
               n++;
            end
         end
         chk(n, 8);
         chk(gmin, lim[c]);
      end
   endtask
   task automatic t_start;
      acc(1'b1, irc_pkg::ADDR_START_LO, 8'h30);
      acc(1'b1, irc_pkg::ADDR_START_HI, 8'h12);
      nonius <= 12'h456;
      mtoff <= 12'h111;
      mtc <= 1'b1;
      cmd(1'b0);
      op <= 1'b1;
      wt(4);
      rc(irc_pkg::ADDR_EFF_LO, 8'ha0);
      acc(1'b1, irc_pkg::ADDR_EFF_HI, 8'h00);
      rc(irc_pkg::ADDR_EFF_HI, 8'h68);
      mtc <= 1'b0;
      cmd(1'b1);
      wt(4);
      rc(irc_pkg::ADDR_EFF_LO, 8'h90);
      rc(irc_pkg::ADDR_EFF_HI, 8'h57);
   endtask
   task automatic t_hys;
      int thr[3] = '{127, 254, 509};
      int c0;
      acc(1'b1, irc_pkg::ADDR_RATE_EN, 8'h00);
      for (int k = 0; k < 3; k++) begin
         acc(1'b1, irc_pkg::ADDR_HYS_PH, 8'((k + 1) << 4));
         c0 = count;
         pos <= (k % 2) ? pos + 18'(thr[k]) : pos - 18'(thr[k]);
         wt(40);
         chk(count, c0);
         pos <= (k % 2) ? pos + 18'd20 : pos - 18'd20;
         wt(thr[k] + 40);
         chk(count, c0 + ((k % 2) ? thr[k] + 20 : -(thr[k] + 20)));
      end
   endtask
   task automatic t_ovs;
      cmd(1'b0);
      wt(3);
      chk(ovs, 0);
      acc(1'b1, irc_pkg::ADDR_HYS_PH, 8'h00);
      acc(1'b1, irc_pkg::ADDR_RATE_EN, 8'h07);
      pos <= pos + 18'd200;
      wt(20);
      chk(ovs, 1);
      acc(1'b1, irc_pkg::ADDR_RATE_EN, 8'h00);
      wt(300);
      chk(ovs, 1);
      cmd(1'b0);
      wt(3);
      chk(ovs, 0);
   endtask
   task automatic t_comm;
      logic [17:0] p;
      pbm <= 3'h1;
      for (int n = 1; n <= 16; n++) begin
         acc(1'b1, irc_pkg::ADDR_POLES, 8'(3 * n - 1));
         acc(1'b1, irc_pkg::ADDR_HYS_PH, {4'h0, n[0], 3'h0});
         acc(1'b1, irc_pkg::ADDR_RATE_EN, {n[1], 7'h00});
         for (int j = 0; j < 3; j++) begin
            p = 18'(n * 16411 + j * 70001);
            pos <= p;
            wt(5);
            chk(comm, uvw(p, n, n[0], n[1]));
         end
      end
      pbm <= 3'h0;
      wt(3);
      chk(comm, 3'h0);
   endtask
   task automatic t_hide;
      int c0;
      acc(1'b1, irc_pkg::ADDR_RATE_EN, 8'h10);
      cmd(1'b0);
      wt(3);
      op <= 1'b0;
      cmd(1'b0);
      c0 = count;
      pos <= pos + 18'd32;
      wt(40);
      chk(if_en, 0);
      chk(count, c0);
      op <= 1'b1;
      wt(40);
      chk(count, c0);
      pos <= pos + 18'd5;
      wt(20);
      chk(count, c0 + 5);
   endtask
   initial begin
      repeat (100000) @(posedge clock);
      fails++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      t_regs();
      pos <= 18'd40;
      wt(60);
      t_rate();
      t_start();
      t_hys();
      t_ovs();
      t_comm();
      t_hide();
      chk(too_close, 1'b0);
      finish_test();
   end
endmodule
`default_nettype wire
